// ### spi_pkg.sv
// Purpose: shared constants, register layouts and state codes of the serial port
// Assumes: 16-bit register data placed in the low half of a 32-bit word
// Notes:   packed struct member order fixes every field position
package spi_pkg;
  localparam int WORD_W = 16;
  localparam int REG_W  = 16;
  localparam logic [15:0] REG_PAD = 16'h0000;

  // register offsets
  localparam logic [4:0] OFS_RX   = 5'h00;
  localparam logic [4:0] OFS_TX   = 5'h04;
  localparam logic [4:0] OFS_CTRL = 5'h08;
  localparam logic [4:0] OFS_IRQ  = 5'h0C;
  localparam logic [4:0] OFS_DIAG = 5'h10;

  // queue levels and the top bit index of a word
  localparam logic [3:0] EMPTY_LVL = 4'h0;
  localparam logic [3:0] HALF_LVL  = 4'h4;
  localparam logic [3:0] FULL_LVL  = 4'h8;
  localparam logic [3:0] WORD_TOP  = 4'hF;

  // bit counting
  localparam logic [4:0] BURST_MAX = 5'h10;
  localparam logic [4:0] BITS_SAT  = 5'h1F;

  // divide-by-4 is two clocks per half serial period
  localparam logic [8:0] HALF_MIN = 9'h002;

  localparam logic [1:0] RDY_OFF   = 2'h0;
  localparam logic [1:0] RDY_EDGE  = 2'h1;
  localparam logic [1:0] RDY_LEVEL = 2'h2;

  localparam logic [15:0] TEST_STEP  = 16'h0421;
  localparam logic [15:0] PLAIN_STEP = 16'h0001;

  typedef struct packed {
    logic [2:0] bit_rate_divider;
    logic       mode;
    logic [1:0] rdy;
    logic       module_enable;
    logic       transfer_go;
    logic       select_active_level;
    logic       select_waveform_select;
    logic       sample_edge_select;
    logic       clock_idle_level;
    logic [3:0] len;
  } ctrl_t;

  typedef struct packed {
    logic bo;
    logic ro;
    logic rf;
    logic rh;
    logic rr;
    logic tf;
    logic th;
    logic te;
  } flags_t;

  typedef struct packed {
    flags_t en;
    flags_t st;
  } irq_reg_t;

  typedef struct packed {
    logic       test;
    logic       loop;
    logic       init;
    logic       lock;
    logic [3:0] state;
    logic [3:0] rxcnt;
    logic [3:0] txcnt;
  } diag_t;

  // declaration order gives the reported state code
  typedef enum logic [3:0] {
    ST_IDLE, ST_EXCH, ST_SSB0, ST_T2, ST_BUSY, ST_ACTIVE,
    ST_WAITCNT, ST_CK2SSB1, ST_T3, ST_SSB1, ST_WAITCNT2, ST_READY
  } st_t;

  function automatic logic rdy_used(input logic [1:0] rdy);
    return (rdy == RDY_EDGE) || (rdy == RDY_LEVEL);
  endfunction
endpackage

// ### queue_if.sv
// Purpose: signals between the port logic and one word queue
// Assumes: one clock domain
// Notes:   head is the oldest word, valid while count is non-zero
`timescale 1ns/1ps
`default_nettype none
interface queue_if;
  logic                        push;
  logic [spi_pkg::WORD_W-1:0]  push_data;
  logic                        pop;
  logic                        flush;
  logic [spi_pkg::WORD_W-1:0]  head;
  logic [3:0]                  count;
  modport owner (output push, push_data, pop, flush, input head, count);
  modport store (input push, push_data, pop, flush, output head, count);
endinterface
`default_nettype wire

// ### word_queue.sv
// Purpose: eight-word by sixteen-bit queue
// Assumes: push while full only lands when a pop happens in the same cycle
// Notes:   flush wins over push and pop
`timescale 1ns/1ps
`default_nettype none
module word_queue (
  // clock and reset
  input  wire logic     clk,
  input  wire logic     rst,
  // queue side
  queue_if.store        qi
);
  typedef struct packed {
    logic [7:0][spi_pkg::WORD_W-1:0] mem;
    logic [2:0]                      rd;
    logic [2:0]                      wr;
    logic [3:0]                      cnt;
  } fifo_state_t;

  fifo_state_t s_r;
  fifo_state_t s_nxt;
  logic        do_pop;
  logic        do_push;

  always_comb begin
    s_nxt   = s_r;
    do_pop  = qi.pop && (s_r.cnt != spi_pkg::EMPTY_LVL);
    do_push = qi.push && ((s_r.cnt != spi_pkg::FULL_LVL) || do_pop);
    if (do_push) begin
      s_nxt.mem[s_r.wr] = qi.push_data;
      s_nxt.wr          = s_r.wr + 3'h1;
    end
    if (do_pop) begin
      s_nxt.rd = s_r.rd + 3'h1;
    end
    s_nxt.cnt = s_r.cnt + {3'h0, do_push} - {3'h0, do_pop};
    if (qi.flush) begin
      s_nxt.rd  = '0;
      s_nxt.wr  = '0;
      s_nxt.cnt = spi_pkg::EMPTY_LVL;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign qi.head  = s_r.mem[s_r.rd];
  assign qi.count = s_r.cnt;
endmodule // word_queue
`default_nettype wire

// ### bit_shifter.sv
// Purpose: transmit and receive shift registers, most significant bit first
// Assumes: load, advance and capture come as one-cycle pulses
// Notes:   load left-aligns the low len+1 bits so upper bits never leave
`timescale 1ns/1ps
`default_nettype none
module bit_shifter (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // control
  input  wire logic                        load,
  input  wire logic [spi_pkg::WORD_W-1:0]  load_data,
  input  wire logic [3:0]                  len,
  input  wire logic                        advance,
  input  wire logic                        capture,
  input  wire logic                        din,
  // results
  output logic                             out_bit,
  output logic [spi_pkg::WORD_W-1:0]       rx_word
);
  typedef struct packed {
    logic [spi_pkg::WORD_W-1:0] tx;
    logic [spi_pkg::WORD_W-1:0] rx;
  } shift_state_t;

  shift_state_t s_r;
  shift_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (load) begin
      s_nxt.tx = load_data << (spi_pkg::WORD_TOP - len);
    end else if (advance) begin
      s_nxt.tx = {s_r.tx[spi_pkg::WORD_W-2:0], 1'b0};
    end
    if (capture) begin
      s_nxt.rx = {s_r.rx[spi_pkg::WORD_W-2:0], din};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign out_bit = s_r.tx[spi_pkg::WORD_TOP];
  assign rx_word = s_r.rx;
endmodule // bit_shifter
`default_nettype wire

// ### configurable_serial_port.sv
// Purpose: serial port, master or slave, with eight-word transmit and receive queues
// Assumes: all pin inputs synchronous to clk; slave serial clock well below clk/2
// Notes:   pins and status lag internal state by one clock
// Notes on behaviour
// - transmit port writes are dropped while the module is disabled
// - transmit queue holds eight words, writable whenever not full, even mid-exchange
// - only the low word-length bits of each word are shifted, then next word
// - divider codes 0..7 give clock divided by 4 up to 512
// - master ready input: ignored, falling edge, low level, or reserved
// - mode bit one is master, zero is slave
// - disabling flushes queues, clears go and resets counters and state machine
// - transfer go starts master exchange, reads busy, self-clears when all sent
// - select polarity bit chooses active-high or active-low select
// - master select pulses inactive between words or stays asserted
// - slave receive advances on select release or after word length bits
// - clock idle level follows the polarity bit
// - word length code plus one gives bits per word
// - transmit empty and half read zero when disabled; levels from count
// - receive ready, half and full reflect queued word count
// - receive overflow set on lost word, cleared by receive data read
// - slave select-advance mode flags more than sixteen bits in a burst
// - every status flag has its own interrupt enable
// - test bit picks sample step 0x0421, else 0x1
// - diagnostic field reports the transfer state code
// - phase zero: launch trailing, capture leading; phase one opposite
`timescale 1ns/1ps
`default_nettype none
module configurable_serial_port (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register port
  input  wire logic [4:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  // serial clock pin
  input  wire logic        serial_clock_line_i,
  output logic             serial_clock_line_o,
  output logic             serial_clock_line_oe_n,
  // master-out pin
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe_n,
  // master-in pin
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe_n,
  // select pin
  input  wire logic        sel_i,
  output logic             sel_o,
  output logic             sel_oe_n,
  // peer ready, active low
  input  wire logic        peer_ready_line_n,
  // status outputs
  output logic             irq,
  output logic      [15:0] sample_step
);
  typedef struct packed {
    spi_pkg::ctrl_t  ctrl;
    spi_pkg::flags_t en;
    logic            ro;
    logic            bo;
    logic            test;
    logic            loop;
    logic            init;
    logic            lock;
    spi_pkg::st_t    st;
    logic [8:0]      tick;
    logic [4:0]      hc;
    logic            ck;
    logic [4:0]      bits;
    logic            ss_act;
    logic            rx_pend;
    logic            rdy_prev;
    logic            rdy_seen;
    logic            sclk_prev;
    logic            sel_prev;
    logic [31:0]     rdata;
    logic            sclk_o;
    logic            sclk_oe_n;
    logic            mosi_o;
    logic            mosi_oe_n;
    logic            miso_o;
    logic            miso_oe_n;
    logic            sel_o;
    logic            sel_oe_n;
    logic            irq;
    logic [15:0]     step;
  } port_state_t;

  port_state_t      q_r;
  port_state_t      q_nxt;
  spi_pkg::flags_t  flags;
  spi_pkg::ctrl_t   wctrl;
  spi_pkg::diag_t   wdiag;
  logic [8:0]       hp;
  logic             tdone;
  logic             lead;
  logic             trail;
  logic             cap;
  logic             ld;
  logic [15:0]      ld_data;
  logic             sel_in_act;
  logic             sclk_in;
  logic             rdy_ok;
  logic             rd_pop;
  logic             slave_on;
  logic             din;
  logic             sh_out;
  logic [15:0]      sh_rx;

  queue_if txq ();
  queue_if rxq ();

  word_queue u_txq (.clk(clk), .rst(rst), .qi(txq));
  word_queue u_rxq (.clk(clk), .rst(rst), .qi(rxq));

  assign din = q_r.loop ? sh_out : (q_r.ctrl.mode ? miso_i : mosi_i);

  bit_shifter u_shift (
    .clk       (clk),
    .rst       (rst),
    .load      (ld),
    .load_data (ld_data),
    .len       (q_r.ctrl.len),
    .advance   ((q_r.ctrl.sample_edge_select ? lead : trail) && (q_r.bits != '0)),
    .capture   (cap),
    .din       (din),
    .out_bit   (sh_out),
    .rx_word   (sh_rx)
  );

  always_comb begin
    q_nxt         = q_r;
    wctrl         = spi_pkg::ctrl_t'(reg_wdata[spi_pkg::REG_W-1:0]);
    wdiag         = spi_pkg::diag_t'(reg_wdata[spi_pkg::REG_W-1:0]);
    txq.push      = 1'b0;
    txq.push_data = reg_wdata[spi_pkg::WORD_W-1:0];
    txq.pop       = 1'b0;
    txq.flush     = !q_r.ctrl.module_enable;
    rxq.push      = q_r.rx_pend;
    rxq.push_data = sh_rx;
    rxq.pop       = 1'b0;
    rxq.flush     = !q_r.ctrl.module_enable;
    ld            = 1'b0;
    ld_data       = (txq.count != spi_pkg::EMPTY_LVL) ? txq.head : '0;
    lead          = 1'b0;
    trail         = 1'b0;
    rd_pop        = 1'b0;
    slave_on      = q_r.ctrl.module_enable && !q_r.ctrl.mode;
    hp            = spi_pkg::HALF_MIN << q_r.ctrl.bit_rate_divider;
    tdone         = (q_r.tick == hp - 9'h001);
    sel_in_act    = (sel_i == q_r.ctrl.select_active_level);
    sclk_in       = serial_clock_line_i ^ q_r.ctrl.clock_idle_level;
    rdy_ok        = (q_r.ctrl.rdy == spi_pkg::RDY_LEVEL) ? !peer_ready_line_n : q_r.rdy_seen;
    flags         = '0;
    flags.te      = q_r.ctrl.module_enable && (txq.count == spi_pkg::EMPTY_LVL);
    flags.th      = q_r.ctrl.module_enable && (txq.count <= spi_pkg::FULL_LVL - spi_pkg::HALF_LVL);
    flags.tf      = (txq.count == spi_pkg::FULL_LVL);
    flags.rr      = (rxq.count != spi_pkg::EMPTY_LVL);
    flags.rh      = (rxq.count >= spi_pkg::HALF_LVL);
    flags.rf      = (rxq.count == spi_pkg::FULL_LVL);
    flags.ro      = q_r.ro;
    flags.bo      = q_r.bo;
    q_nxt.rx_pend = 1'b0;

    // reads; the receive read clears the error flags before any new set
    if (reg_rd) begin
      case (reg_addr)
        spi_pkg::OFS_RX: begin
          q_nxt.rdata = q_r.ctrl.module_enable ? {spi_pkg::REG_PAD, rxq.head} : '0;
          rd_pop      = (rxq.count != spi_pkg::EMPTY_LVL);
          q_nxt.ro    = 1'b0;
          q_nxt.bo    = 1'b0;
        end
        spi_pkg::OFS_CTRL: q_nxt.rdata = {spi_pkg::REG_PAD, q_r.ctrl};
        spi_pkg::OFS_IRQ:  q_nxt.rdata = {spi_pkg::REG_PAD, q_r.en, flags};
        spi_pkg::OFS_DIAG: q_nxt.rdata = {spi_pkg::REG_PAD, q_r.test, q_r.loop, q_r.init,
                                          q_r.lock, q_r.st, rxq.count, txq.count};
        default:           q_nxt.rdata = '0;
      endcase
    end
    rxq.pop = rd_pop;

    // master sequencer; the enum order is the reported state code
    q_nxt.tick = ((q_r.st == spi_pkg::ST_T2) || (q_r.st == spi_pkg::ST_WAITCNT) ||
                  (q_r.st == spi_pkg::ST_CK2SSB1) || (q_r.st == spi_pkg::ST_WAITCNT2))
                 && !tdone ? q_r.tick + 9'h001 : '0;
    if (q_r.ctrl.mode) begin
      case (q_r.st)
        spi_pkg::ST_IDLE: begin
          if (q_r.ctrl.transfer_go) begin
            if (txq.count != spi_pkg::EMPTY_LVL) begin
              q_nxt.st = spi_pkg::rdy_used(q_r.ctrl.rdy) ? spi_pkg::ST_EXCH
                                                         : spi_pkg::ST_SSB0;
            end else begin
              q_nxt.ctrl.transfer_go = 1'b0;
            end
          end
        end
        spi_pkg::ST_EXCH, spi_pkg::ST_READY: begin
          if (rdy_ok) begin
            q_nxt.rdy_seen = 1'b0;
            q_nxt.st       = spi_pkg::ST_SSB0;
          end
        end
        spi_pkg::ST_SSB0: begin
          q_nxt.ss_act = 1'b1;
          q_nxt.st     = spi_pkg::ST_T2;
        end
        spi_pkg::ST_T2: if (tdone) q_nxt.st = spi_pkg::ST_ACTIVE;
        spi_pkg::ST_ACTIVE: begin
          ld         = 1'b1;
          q_nxt.bits = '0;
          q_nxt.hc   = '0;
          q_nxt.ck   = 1'b0;
          q_nxt.st   = spi_pkg::ST_WAITCNT;
        end
        spi_pkg::ST_WAITCNT: begin
          if (tdone) begin
            q_nxt.ck = !q_r.ck;
            lead     = !q_r.ck;
            trail    = q_r.ck;
            q_nxt.hc = q_r.hc + 5'h01;
            if (q_r.hc == {q_r.ctrl.len, 1'b1}) q_nxt.st = spi_pkg::ST_CK2SSB1;
          end
        end
        spi_pkg::ST_CK2SSB1: begin
          if (tdone) begin
            if ((txq.count == spi_pkg::EMPTY_LVL) || q_r.ctrl.select_waveform_select) begin
              q_nxt.st = spi_pkg::ST_SSB1;
            end else begin
              q_nxt.st = spi_pkg::rdy_used(q_r.ctrl.rdy) ? spi_pkg::ST_READY
                                                         : spi_pkg::ST_ACTIVE;
            end
          end
        end
        spi_pkg::ST_SSB1: begin
          q_nxt.ss_act = 1'b0;
          if (txq.count == spi_pkg::EMPTY_LVL) begin
            q_nxt.ctrl.transfer_go = 1'b0;
            q_nxt.st       = spi_pkg::ST_IDLE;
          end else begin
            q_nxt.st = spi_pkg::ST_WAITCNT2;
          end
        end
        spi_pkg::ST_WAITCNT2: begin
          if (tdone) begin
            q_nxt.st = spi_pkg::rdy_used(q_r.ctrl.rdy) ? spi_pkg::ST_READY
                                                       : spi_pkg::ST_SSB0;
          end
        end
        default: q_nxt.st = spi_pkg::ST_IDLE;
      endcase
    end else if (slave_on) begin
      q_nxt.sclk_prev = sclk_in;
      q_nxt.sel_prev  = sel_in_act;
      if (sel_in_act && !q_r.sel_prev) begin
        ld         = 1'b1;
        q_nxt.bits = '0;
      end else if (sel_in_act) begin
        lead  = sclk_in && !q_r.sclk_prev;
        trail = !sclk_in && q_r.sclk_prev;
      end
      if (!sel_in_act && q_r.sel_prev && q_r.ctrl.select_waveform_select && (q_r.bits != '0)) begin
        q_nxt.rx_pend = 1'b1;
      end
    end

    // bit counting shared by both modes
    cap = q_r.ctrl.sample_edge_select ? trail : lead;
    if (cap) begin
      if (slave_on && q_r.ctrl.select_waveform_select) begin
        if (q_r.bits == spi_pkg::BURST_MAX) q_nxt.bo = 1'b1;
        if (q_r.bits != spi_pkg::BITS_SAT) q_nxt.bits = q_r.bits + 5'h01;
      end else if (q_r.bits == {1'b0, q_r.ctrl.len}) begin
        q_nxt.bits    = '0;
        q_nxt.rx_pend = 1'b1;
        ld            = slave_on;
      end else begin
        q_nxt.bits = q_r.bits + 5'h01;
      end
    end
    if (ld) begin
      txq.pop = (txq.count != spi_pkg::EMPTY_LVL);
    end

    // full receive queue drops its oldest word to take the new one
    if (q_r.rx_pend && (rxq.count == spi_pkg::FULL_LVL) && !rd_pop) begin
      rxq.pop  = 1'b1;
      q_nxt.ro = 1'b1;
    end
    q_nxt.rdy_prev = peer_ready_line_n;
    if (q_r.rdy_prev && !peer_ready_line_n) q_nxt.rdy_seen = 1'b1;

    // writes come after the sequencer so a go write beats the self-clear
    if (reg_wr) begin
      case (reg_addr)
        spi_pkg::OFS_TX: begin
          txq.push = q_r.ctrl.module_enable && (txq.count != spi_pkg::FULL_LVL);
        end
        spi_pkg::OFS_CTRL: begin
          q_nxt.ctrl     = wctrl;
          q_nxt.ctrl.transfer_go = (q_nxt.ctrl.transfer_go || wctrl.transfer_go) && wctrl.mode;
        end
        spi_pkg::OFS_IRQ:  q_nxt.en =
          spi_pkg::flags_t'(reg_wdata[spi_pkg::REG_W-1:spi_pkg::REG_W/2]);
        spi_pkg::OFS_DIAG: begin
          q_nxt.test = wdiag.test;
          q_nxt.loop = wdiag.loop;
          q_nxt.init = wdiag.init;
          q_nxt.lock = wdiag.lock;
        end
        default: ;
      endcase
    end

    if (!q_nxt.ctrl.module_enable || q_r.init) begin
      q_nxt.st       = spi_pkg::ST_IDLE;
      q_nxt.ctrl.transfer_go = 1'b0;
      q_nxt.ss_act   = 1'b0;
      q_nxt.bits     = '0;
      q_nxt.hc       = '0;
      q_nxt.ck       = 1'b0;
      q_nxt.tick     = '0;
      q_nxt.rx_pend  = 1'b0;
      q_nxt.rdy_seen = 1'b0;
      q_nxt.sel_prev = 1'b0;
    end
    if (!q_nxt.ctrl.module_enable) begin
      q_nxt.ro = 1'b0;
      q_nxt.bo = 1'b0;
    end

    // pins; oe_n low while this end drives
    q_nxt.sclk_o    = q_r.ck ^ q_r.ctrl.clock_idle_level;
    q_nxt.sclk_oe_n = !(q_r.ctrl.module_enable && q_r.ctrl.mode);
    q_nxt.mosi_o    = sh_out;
    q_nxt.mosi_oe_n = !(q_r.ctrl.module_enable && q_r.ctrl.mode);
    q_nxt.sel_o     = q_r.ss_act ? q_r.ctrl.select_active_level : !q_r.ctrl.select_active_level;
    q_nxt.sel_oe_n  = !(q_r.ctrl.module_enable && q_r.ctrl.mode);
    q_nxt.miso_o    = sh_out;
    q_nxt.miso_oe_n = !(slave_on && sel_in_act);
    q_nxt.irq       = |(flags & q_r.en);
    q_nxt.step      = q_r.test ? spi_pkg::TEST_STEP : spi_pkg::PLAIN_STEP;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_r           <= '0;
      q_r.sclk_oe_n <= 1'b1;
      q_r.mosi_oe_n <= 1'b1;
      q_r.miso_oe_n <= 1'b1;
      q_r.sel_oe_n  <= 1'b1;
      q_r.sel_o     <= 1'b1;
      q_r.rdy_prev  <= 1'b1;
      q_r.step      <= spi_pkg::PLAIN_STEP;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign reg_rdata              = q_r.rdata;
  assign serial_clock_line_o    = q_r.sclk_o;
  assign serial_clock_line_oe_n = q_r.sclk_oe_n;
  assign mosi_o                 = q_r.mosi_o;
  assign mosi_oe_n              = q_r.mosi_oe_n;
  assign miso_o                 = q_r.miso_o;
  assign miso_oe_n              = q_r.miso_oe_n;
  assign sel_o                  = q_r.sel_o;
  assign sel_oe_n               = q_r.sel_oe_n;
  assign irq                    = q_r.irq;
  assign sample_step            = q_r.step;
endmodule // configurable_serial_port
`default_nettype wire

// ### spi_port_asserts.sv
// Purpose: port-level checks of the serial port
// Assumes: settings change only through bus writes
// Notes:   shadows of ctrl, irq enables and test bit follow the writes
`timescale 1ns/1ps
`default_nettype none
module spi_port_asserts (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // register port
  input wire logic [4:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  // pins and status outputs
  input wire logic        serial_clock_line_o,
  input wire logic        serial_clock_line_oe_n,
  input wire logic        sel_i,
  input wire logic        sel_o,
  input wire logic        sel_oe_n,
  input wire logic        miso_oe_n,
  input wire logic        irq,
  input wire logic [15:0] sample_step
);
  spi_pkg::ctrl_t cfg_r;
  logic [7:0]     ien_r;
  logic           tst_r;
  logic [1:0]     age_r;
  logic [8:0]     since_r;
  // age hides the pin lag after any write
  wire logic      calm = age_r == 2'h3;
  wire logic      mst = cfg_r.module_enable && cfg_r.mode;
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r   <= '0;
      ien_r   <= 8'h00;
      tst_r   <= 1'b0;
      age_r   <= 2'h0;
      since_r <= 9'h000;
    end else begin
      if (reg_wr && reg_addr == spi_pkg::OFS_CTRL) cfg_r <= reg_wdata[15:0];
      if (reg_wr && reg_addr == spi_pkg::OFS_IRQ) ien_r <= reg_wdata[15:8];
      if (reg_wr && reg_addr == spi_pkg::OFS_DIAG) tst_r <= reg_wdata[15];
      age_r   <= reg_wr ? 2'h0 : age_r + {1'b0, age_r != 2'h3};
      since_r <= $changed(serial_clock_line_o) ? 9'h000 : since_r + {8'h00, since_r != 9'h1FF};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence irq_rd;
    reg_rd && reg_addr == spi_pkg::OFS_IRQ;
  endsequence
  chk_master_drive: assert property (calm |-> serial_clock_line_oe_n == !mst)
    else $error("clock pin drive does not follow mode");
  chk_idle_level: assert property (calm && mst && $past(sel_o) != cfg_r.select_active_level
    && sel_o != cfg_r.select_active_level |-> serial_clock_line_o == cfg_r.clock_idle_level)
    else $error("serial clock not at idle level");
  chk_half_period: assert property (calm && mst && $changed(serial_clock_line_o)
    |-> since_r >= (spi_pkg::HALF_MIN << cfg_r.bit_rate_divider) - 9'h001)
    else $error("serial clock half period too short");
  chk_irq_mask: assert property (calm && irq |-> ien_r != 8'h00)
    else $error("interrupt with all enables clear");
  chk_step_sel: assert property (calm |-> sample_step
    == (tst_r ? spi_pkg::TEST_STEP : spi_pkg::PLAIN_STEP))
    else $error("sample step wrong");
  chk_off_flags: assert property ((calm && !cfg_r.module_enable) and irq_rd
    |=> reg_rdata[1:0] == 2'h0)
    else $error("transmit flags set while disabled");
  chk_miso_float: assert property (calm && sel_i != cfg_r.select_active_level
    && $past(sel_i) != cfg_r.select_active_level && $past(sel_i, 2) != cfg_r.select_active_level |-> miso_oe_n)
    else $error("slave output driven while deselected");
  chk_disable_drop: assert property (mst && reg_wr && reg_addr == spi_pkg::OFS_CTRL
    && !reg_wdata[9] |-> ##[1:3] (serial_clock_line_oe_n && sel_oe_n))
    else $error("pins still driven after disable");
endmodule // spi_port_asserts
bind configurable_serial_port spi_port_asserts u_chk (.clk, .rst, .reg_addr, .reg_wr,
  .reg_rd, .reg_wdata, .reg_rdata, .serial_clock_line_o, .serial_clock_line_oe_n, .sel_i,
  .sel_o, .sel_oe_n, .miso_oe_n, .irq, .sample_step);
`default_nettype wire

// ### serial_peer_model.sv
// Purpose: slave peer on the link, phase 0 with idle-low clock
// Assumes: select active low
// Notes:   a released data line shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module serial_peer_model (
  // link
  input  wire logic        sck,
  input  wire logic        sel_n,
  input  wire logic        mosi,
  output logic             miso,
  // words
  input  wire logic [15:0] tx_word,
  output logic      [15:0] rx_word
);
  logic [15:0] sh = 16'h0000;
  always @(negedge sel_n) sh = tx_word;
  always @(posedge sck) if (!sel_n) rx_word = {rx_word[14:0], mosi};
  always @(negedge sck) if (!sel_n) sh = {sh[14:0], 1'b0};
  assign miso = sel_n ? ~sh[15] : sh[15];
endmodule // serial_peer_model
`default_nettype wire

// ### configurable_spi_fifo_port_tb.sv
// Purpose: self-checking bench of the serial port as link master
// Assumes: slave peer model on the link, select active low
// Notes:   each scenario task judges its own results
`timescale 1ns/1ps
`default_nettype none
module configurable_spi_fifo_port_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  ra = 5'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] wd = 32'h0;
  logic        rdy_n = 1'b1;
  logic [31:0] rdat;
  logic [15:0] step;
  logic [15:0] prx;
  logic        irq, sck, sck_e, mo, mo_e, mi, mi_e, so, so_e, pm;
  wire logic   ck_w = sck_e ? 1'b0 : sck;
  wire logic   mo_w = mo_e ? 1'b0 : mo;
  wire logic   mi_w = mi_e ? pm : mi;
  wire logic   ss_w = so_e ? 1'b1 : so;
  int          err_total = 0;
  int          n_compared = 0;
  configurable_serial_port u_dut (.clk(clk), .rst(rst), .reg_addr(ra), .reg_wr(wr),
    .reg_rd(rd), .reg_wdata(wd), .reg_rdata(rdat), .serial_clock_line_i(ck_w),
    .serial_clock_line_o(sck), .serial_clock_line_oe_n(sck_e), .mosi_i(mo_w), .mosi_o(mo),
    .mosi_oe_n(mo_e), .miso_i(mi_w), .miso_o(mi), .miso_oe_n(mi_e), .sel_i(ss_w),
    .sel_o(so), .sel_oe_n(so_e), .peer_ready_line_n(rdy_n), .irq(irq), .sample_step(step));
  serial_peer_model u_peer (.sck(ck_w), .sel_n(ss_w), .mosi(mo_w), .miso(pm),
    .tx_word(16'h9600), .rx_word(prx));
  initial forever #4 clk = ~clk;
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    #1 ra = a;
    wd = {16'h0000, d};
    wr = 1'b1;
    @(posedge clk);
    #1 wr = 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    @(posedge clk);
    #1 ra = a;
    rd = 1'b1;
    @(posedge clk);
    #1 rd = 1'b0;
    cmp(nm, e, rdat & m);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 400; i++) begin
      rchk("poll", spi_pkg::OFS_CTRL, 32'h0, 32'h0);
      if (rdat[8] === 1'b0) return;
    end
    err_total++;
    close_out;
  endtask
  task automatic t_regs;
    rchk("ctrl", spi_pkg::OFS_CTRL, 32'hFFFFFFFF, 32'h0);
    rchk("irq", spi_pkg::OFS_IRQ, 32'hFFFFFFFF, 32'h0);
    rchk("diag", spi_pkg::OFS_DIAG, 32'hFFFFFFFF, 32'h0);
    rchk("hole", 5'h14, 32'hFFFFFFFF, 32'h0);
    wreg(spi_pkg::OFS_TX, 16'h1234);
    rchk("txcnt", spi_pkg::OFS_DIAG, 32'hF, 32'h0);
  endtask
  task automatic t_fill;
    wreg(spi_pkg::OFS_CTRL, 16'h3207);
    rchk("flags", spi_pkg::OFS_IRQ, 32'hFF, 32'h03);
    for (int i = 0; i < 9; i++) wreg(spi_pkg::OFS_TX, 16'(i));
    rchk("txcnt", spi_pkg::OFS_DIAG, 32'hF, 32'h8);
    rchk("flags", spi_pkg::OFS_IRQ, 32'hFF, 32'h04);
    wreg(spi_pkg::OFS_CTRL, 16'h3007);
    rchk("counts", spi_pkg::OFS_DIAG, 32'hFFF, 32'h0);
    rchk("flags", spi_pkg::OFS_IRQ, 32'hFF, 32'h00);
  endtask
  task automatic t_xchg;
    wreg(spi_pkg::OFS_CTRL, 16'h3247);
    wreg(spi_pkg::OFS_TX, 16'hA5C3);
    wreg(spi_pkg::OFS_TX, 16'h0F5A);
    wreg(spi_pkg::OFS_CTRL, 16'h3347);
    rchk("go", spi_pkg::OFS_CTRL, 32'h100, 32'h100);
    wait_idle();
    cmp("peer", 32'hC35A, {16'h0000, prx});
    rchk("rx0", spi_pkg::OFS_RX, 32'hFF, 32'h96);
    rchk("rx1", spi_pkg::OFS_RX, 32'hFF, 32'h96);
    rchk("counts", spi_pkg::OFS_DIAG, 32'hFF, 32'h0);
  endtask
  task automatic t_rdy;
    wreg(spi_pkg::OFS_CTRL, 16'h3047);
    wreg(spi_pkg::OFS_CTRL, 16'h3A47);
    wreg(spi_pkg::OFS_TX, 16'h00FF);
    wreg(spi_pkg::OFS_CTRL, 16'h3B47);
    repeat (40) @(posedge clk);
    rchk("state", spi_pkg::OFS_DIAG, 32'hF00, 32'h100);
    rchk("go", spi_pkg::OFS_CTRL, 32'h100, 32'h100);
    rdy_n = 1'b0;
    wait_idle();
    rchk("rx", spi_pkg::OFS_RX, 32'hFF, 32'h96);
    rdy_n = 1'b1;
  endtask
  task automatic t_misc;
    wreg(spi_pkg::OFS_IRQ, 16'h0100);
    repeat (3) @(posedge clk);
    #1 cmp("irq", 32'h1, {31'h0, irq});
    wreg(spi_pkg::OFS_IRQ, 16'h0000);
    repeat (3) @(posedge clk);
    #1 cmp("irq", 32'h0, {31'h0, irq});
    wreg(spi_pkg::OFS_DIAG, 16'h8000);
    repeat (3) @(posedge clk);
    #1;
    cmp("step", 32'h0421, {16'h0000, step});
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    t_regs();
    t_fill();
    t_xchg();
    t_rdy();
    t_misc();
    close_out();
  end
endmodule // configurable_spi_fifo_port_tb
`default_nettype wire
